// >>> common/ufc_cfg.svh
// register offsets, field positions, reset values and codes for the line format block
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH

// byte offsets on the register bus (word aligned)
`define UFC_OFF_DIV_LO 8'h00
`define UFC_OFF_DIV_HI 8'h04
`define UFC_OFF_IEN 8'h04
`define UFC_OFF_IID 8'h08
`define UFC_OFF_EFR 8'h08
`define UFC_OFF_LFC 8'h0c
`define UFC_OFF_FEN 8'h10

// line_format_control field positions
`define UFC_LFC_DIVISOR_ACCESS 7
`define UFC_LFC_BREAK 6
`define UFC_LFC_FORCED_PARITY 5
`define UFC_LFC_EVEN_PARITY 4
`define UFC_LFC_PARITY_ENABLE 3
`define UFC_LFC_STOP_BITS 2

// enhanced_feature_register field holding the enhanced interrupt enable
`define UFC_EFR_INT_ENABLE 4

// reset values
`define UFC_LFC_RESET 8'h00
`define UFC_EFR_RESET 8'h00
`define UFC_IEN_RESET 8'h00
`define UFC_DIV_RESET 8'h00
`define UFC_IID_NONE 6'h01

// identification codes, bits five down to zero
`define UFC_ID_LINE_STATUS 6'h06
`define UFC_ID_RX_DATA 6'h04
`define UFC_ID_RX_TIMEOUT 6'h0c
`define UFC_ID_TX_EMPTY 6'h02
`define UFC_ID_MODEM 6'h00
`define UFC_ID_XOFF_SPECIAL 6'h10
`define UFC_ID_FLOW_CHANGE 6'h20

// stop length in half bit times
`define UFC_STOP_ONE 3'h2
`define UFC_STOP_ONE_HALF 3'h3
`define UFC_STOP_TWO 3'h4

`endif

// >>> common/ufc_pkg.sv
// types shared by the line format and interrupt identification block
package ufc_pkg;

  // source index, lowest index is highest priority
  typedef enum logic [2:0] {
    UFC_SRC_LINE_STATUS,
    UFC_SRC_RX_DATA,
    UFC_SRC_RX_TIMEOUT,
    UFC_SRC_TX_EMPTY,
    UFC_SRC_MODEM,
    UFC_SRC_SPECIAL,
    UFC_SRC_FLOW_CHANGE,
    UFC_SRC_XOFF
  } ufc_src_t;

  typedef enum logic [1:0] {
    UFC_PAR_NONE,
    UFC_PAR_ODD,
    UFC_PAR_EVEN,
    UFC_PAR_FORCED
  } ufc_par_mode_t;

  // bus data phase progress
  typedef enum logic [1:0] {
    UFC_PH_IDLE,
    UFC_PH_WAIT,
    UFC_PH_DONE
  } ufc_phase_t;

  // one-cycle event pulses from the neighbouring transceiver blocks
  typedef struct packed {
    logic line_status;
    logic rx_data;
    logic rx_timeout;
    logic tx_empty;
    logic modem;
    logic special_char;
    logic flow_change;
    logic xoff_seen;
    logic xon_seen;
  } ufc_events_t;

  // decoded character format handed to transmitter and receiver
  typedef struct packed {
    logic [3:0] data_bits;
    logic [2:0] stop_halves;
    ufc_par_mode_t parity_mode;
    logic forced_value;
  } ufc_fmt_t;

  typedef struct packed {
    logic [7:0] line_format_control;
    logic [7:0] enhanced_feature_register;
    logic [7:0] source_enable;
    logic fifo_enable;
    logic [15:0] divisor;
    logic [6:0] pending;
    logic xoff_hold;
    logic cur_valid;
    ufc_src_t cur_src;
    ufc_phase_t phase;
    logic [7:0] dp_addr;
    logic dp_write;
    logic [31:0] hrdata;
    logic irq;
    logic tx_line;
    logic tx_parity;
    logic rx_parity_err;
    ufc_fmt_t fmt;
  } ufc_state_t;

endpackage : ufc_pkg

// >>> src/ufc_line_format.sv
// interrupt identification and line format control with an ahb-lite register slave
// Function
// - rank pending sources in six levels; identification read returns the code of the reported source.
// - while one interrupt is reported and unserviced, no other source is reported.
// - identification read clears only the reported source; lower ones show next read.
// - line status is top priority with code 000110.
// - level two: received data 000100, receive timeout 001100.
// - bits three to one code levels one to four; transmit empty 000010, modem 000000.
// - xoff or special character gives 010000; cts/rts change gives 100000.
// - identification bits seven and six read one with fifos enabled, else zero.
// - identification bits five and four only active with enhanced interrupt enable set.
// - xoff indication stays set until matching xon characters arrive.
// - identification bit zero is zero when pending, one when idle and after reset.
// - divisor access bit switches decoding to divisor latch and enhanced feature register.
// - while divisor access bit is set, the general registers cannot be reached; line format control stays readable and writable.
// - break bit holds the serial transmit output low until cleared.
// - forced parity: parity bit is one when even bit clear, zero when set.
// - unforced parity: even bit zero gives odd parity, one gives even parity.
// - parity enable adds a parity bit on transmit and checks it on receive.
// - stop bit field sets stop length together with the word length.
// - word length field selects character length for transmit and receive.
// - after reset all line format fields are zero.
// - stop field zero gives one stop; one gives 1.5 for five bits, else two.
// - word length 00 five, 01 six, 10 seven, 11 eight data bits.
`include "ufc_cfg.svh"

module ufc_line_format (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire ufc_pkg::ufc_events_t events,
  input wire logic tx_serial,
  input wire logic [7:0] tx_char,
  input wire logic [7:0] rx_char,
  input wire logic rx_parity_bit,
  output logic tx_line,
  output logic tx_parity,
  output logic rx_parity_err,
  output ufc_pkg::ufc_fmt_t fmt,
  output logic [15:0] divisor,
  output logic [7:0] enhanced_feature_register,
  output logic irq
);

  ufc_pkg::ufc_state_t st_reg;
  ufc_pkg::ufc_state_t st_next;

  // identification code of one source
  function automatic logic [5:0] id_code(input ufc_pkg::ufc_src_t src);
    unique case (src)
      ufc_pkg::UFC_SRC_LINE_STATUS: id_code = `UFC_ID_LINE_STATUS;
      ufc_pkg::UFC_SRC_RX_DATA: id_code = `UFC_ID_RX_DATA;
      ufc_pkg::UFC_SRC_RX_TIMEOUT: id_code = `UFC_ID_RX_TIMEOUT;
      ufc_pkg::UFC_SRC_TX_EMPTY: id_code = `UFC_ID_TX_EMPTY;
      ufc_pkg::UFC_SRC_MODEM: id_code = `UFC_ID_MODEM;
      ufc_pkg::UFC_SRC_SPECIAL: id_code = `UFC_ID_XOFF_SPECIAL;
      ufc_pkg::UFC_SRC_FLOW_CHANGE: id_code = `UFC_ID_FLOW_CHANGE;
      ufc_pkg::UFC_SRC_XOFF: id_code = `UFC_ID_XOFF_SPECIAL;
    endcase
  endfunction : id_code

  // parity bit for a character under the programmed format; none yields zero
  function automatic logic parity_of(input logic [7:0] ch, input ufc_pkg::ufc_fmt_t f);
    logic [7:0] masked;
    masked = ch & (8'hff >> (4'h8 - f.data_bits));
    unique case (f.parity_mode)
      ufc_pkg::UFC_PAR_NONE: parity_of = 1'b0;
      ufc_pkg::UFC_PAR_ODD: parity_of = ~(^masked);
      ufc_pkg::UFC_PAR_EVEN: parity_of = ^masked;
      ufc_pkg::UFC_PAR_FORCED: parity_of = f.forced_value;
    endcase
  endfunction : parity_of

  // decode of the line format register into the format handed out
  function automatic ufc_pkg::ufc_fmt_t decode_fmt(input logic [7:0] lfc);
    ufc_pkg::ufc_fmt_t f;
    f.data_bits = 4'h5 + {2'h0, lfc[1:0]};
    if (!lfc[`UFC_LFC_STOP_BITS]) begin
      f.stop_halves = `UFC_STOP_ONE;
    end else if (lfc[1:0] == 2'h0) begin
      f.stop_halves = `UFC_STOP_ONE_HALF;
    end else begin
      f.stop_halves = `UFC_STOP_TWO;
    end
    if (!lfc[`UFC_LFC_PARITY_ENABLE]) begin
      f.parity_mode = ufc_pkg::UFC_PAR_NONE;
    end else if (lfc[`UFC_LFC_FORCED_PARITY]) begin
      f.parity_mode = ufc_pkg::UFC_PAR_FORCED;
    end else if (lfc[`UFC_LFC_EVEN_PARITY]) begin
      f.parity_mode = ufc_pkg::UFC_PAR_EVEN;
    end else begin
      f.parity_mode = ufc_pkg::UFC_PAR_ODD;
    end
    f.forced_value = ~lfc[`UFC_LFC_EVEN_PARITY];
    decode_fmt = f;
  endfunction : decode_fmt

  logic [7:0] live_mask;
  logic any_live;
  ufc_pkg::ufc_src_t top_src;
  logic eff_valid;
  ufc_pkg::ufc_src_t eff_src;
  logic enh_int;
  logic addr_take;
  logic dlab;
  logic [7:0] iid_value;
  logic [7:0] evt_set;

  // sources that count: enabled and pending; the enhanced ones need the enhanced enable
  always_comb begin
    enh_int = st_reg.enhanced_feature_register[`UFC_EFR_INT_ENABLE];
    evt_set = {events.xoff_seen, events.flow_change, events.special_char, events.modem,
               events.tx_empty, events.rx_timeout, events.rx_data, events.line_status};
    live_mask[6:0] = st_reg.pending & st_reg.source_enable[6:0];
    live_mask[7] = st_reg.xoff_hold & st_reg.source_enable[5];
    live_mask[5] = live_mask[5] & enh_int;
    live_mask[6] = live_mask[6] & enh_int;
    live_mask[7] = live_mask[7] & enh_int;
    any_live = |live_mask;
  end

  // fixed priority pick, lowest index wins
  always_comb begin
    top_src = ufc_pkg::UFC_SRC_LINE_STATUS;
    for (int i = 7; i >= 0; i--) begin
      if (live_mask[i]) begin
        top_src = ufc_pkg::ufc_src_t'(3'(i));
      end
    end
    // a reported source stays reported until serviced, even if a higher one arrives
    if (st_reg.cur_valid) begin
      eff_valid = 1'b1;
      eff_src = st_reg.cur_src;
    end else begin
      eff_valid = any_live;
      eff_src = top_src;
    end
  end

  // identification value as read; bit zero low means something is pending
  always_comb begin
    iid_value = {{2{st_reg.fifo_enable}}, `UFC_IID_NONE};
    if (eff_valid) begin
      iid_value[5:0] = id_code(eff_src);
    end
  end

  assign dlab = st_reg.line_format_control[`UFC_LFC_DIVISOR_ACCESS];
  assign addr_take = hsel & htrans[1] & hready;

  // next state of the whole block
  always_comb begin
    st_next = st_reg;
    // events set their sticky pending bits
    st_next.pending = st_reg.pending | evt_set[6:0];
    // xoff indication holds until xon; an xoff in the same cycle as xon wins
    if (events.xoff_seen) begin
      st_next.xoff_hold = 1'b1;
    end else if (events.xon_seen) begin
      st_next.xoff_hold = 1'b0;
    end
    // freeze the source being reported until it is serviced
    if (!st_reg.cur_valid && any_live) begin
      st_next.cur_valid = 1'b1;
      st_next.cur_src = top_src;
    end
    // drop a frozen report whose source was disabled meanwhile
    if (st_reg.cur_valid && !live_mask[st_reg.cur_src]) begin
      st_next.cur_valid = 1'b0;
    end

    // bus: a taken address phase leads to one wait cycle, then the answer
    unique case (st_reg.phase)
      ufc_pkg::UFC_PH_IDLE, ufc_pkg::UFC_PH_DONE: begin
        if (addr_take) begin
          st_next.phase = ufc_pkg::UFC_PH_WAIT;
          st_next.dp_addr = haddr[7:0];
          st_next.dp_write = hwrite;
        end else begin
          st_next.phase = ufc_pkg::UFC_PH_IDLE;
        end
      end
      ufc_pkg::UFC_PH_WAIT: begin
        st_next.phase = ufc_pkg::UFC_PH_DONE;
        st_next.hrdata = 32'h0000_0000;
        if (st_reg.dp_write) begin
          // writes; general registers except line format control ignored while divisor access is set
          unique case (st_reg.dp_addr)
            `UFC_OFF_LFC: st_next.line_format_control = hwdata[7:0];
            `UFC_OFF_DIV_LO: if (dlab) st_next.divisor[7:0] = hwdata[7:0];
            `UFC_OFF_IEN: begin
              if (dlab) begin
                st_next.divisor[15:8] = hwdata[7:0];
              end else begin
                st_next.source_enable = {1'b0, hwdata[6:0]};
              end
            end
            `UFC_OFF_EFR: if (dlab) st_next.enhanced_feature_register = hwdata[7:0];
            `UFC_OFF_FEN: if (!dlab) st_next.fifo_enable = hwdata[0];
            default: ;
          endcase
        end else begin
          // reads; unmapped and hidden offsets read as zero
          unique case (st_reg.dp_addr)
            `UFC_OFF_LFC: st_next.hrdata = {24'h0, st_reg.line_format_control};
            `UFC_OFF_DIV_LO: begin
              if (dlab) st_next.hrdata = {24'h0, st_reg.divisor[7:0]};
            end
            `UFC_OFF_IEN: begin
              if (dlab) begin
                st_next.hrdata = {24'h0, st_reg.divisor[15:8]};
              end else begin
                st_next.hrdata = {24'h0, st_reg.source_enable};
              end
            end
            `UFC_OFF_IID: begin
              if (dlab) begin
                st_next.hrdata = {24'h0, st_reg.enhanced_feature_register};
              end else begin
                st_next.hrdata = {24'h0, iid_value};
                // servicing clears only the reported source; a new event still wins
                if (eff_valid) begin
                  st_next.cur_valid = 1'b0;
                  if (eff_src != ufc_pkg::UFC_SRC_XOFF) begin
                    st_next.pending[eff_src] = evt_set[eff_src];
                  end
                end
              end
            end
            `UFC_OFF_FEN: if (!dlab) st_next.hrdata = {31'h0, st_reg.fifo_enable};
            default: ;
          endcase
        end
      end
      default: st_next.phase = ufc_pkg::UFC_PH_IDLE;
    endcase

    // interrupt line follows whether anything enabled remains pending
    st_next.irq = any_live | st_next.cur_valid;
    // break overrides the serial data, the line holds low while set
    st_next.tx_line = st_reg.line_format_control[`UFC_LFC_BREAK] ? 1'b0 : tx_serial;
    st_next.fmt = decode_fmt(st_next.line_format_control);
    st_next.tx_parity = parity_of(tx_char, st_reg.fmt);
    // received parity checked only when parity is enabled
    st_next.rx_parity_err = (st_reg.fmt.parity_mode != ufc_pkg::UFC_PAR_NONE) &&
                            (parity_of(rx_char, st_reg.fmt) != rx_parity_bit);
  end

  // single register stage for all state; everything clears to its default
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
      st_reg.line_format_control <= `UFC_LFC_RESET;
      st_reg.enhanced_feature_register <= `UFC_EFR_RESET;
      st_reg.source_enable <= `UFC_IEN_RESET;
      st_reg.divisor <= {`UFC_DIV_RESET, `UFC_DIV_RESET};
      st_reg.phase <= ufc_pkg::UFC_PH_IDLE;
      st_reg.tx_line <= 1'b1;
      st_reg.fmt <= '{4'h5, `UFC_STOP_ONE, ufc_pkg::UFC_PAR_NONE, 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register, hresp tied low; the wait cycle keeps hrdata a flop
  assign hreadyout = (st_reg.phase != ufc_pkg::UFC_PH_WAIT);
  assign hresp = 1'b0;
  assign hrdata = st_reg.hrdata;
  assign tx_line = st_reg.tx_line;
  assign tx_parity = st_reg.tx_parity;
  assign rx_parity_err = st_reg.rx_parity_err;
  assign fmt = st_reg.fmt;
  assign divisor = st_reg.divisor;
  assign enhanced_feature_register = st_reg.enhanced_feature_register;
  assign irq = st_reg.irq;

  // hsize is not decoded: only whole-word transfers are supported
  logic unused_hsize;
  assign unused_hsize = ^hsize;

endmodule : ufc_line_format

// >>> tb/ufc_line_format_assertions.sv
// port-level checks of bus timing and decoded character format
module ufc_line_format_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic tx_serial,
  input wire logic tx_line,
  input wire logic tx_parity,
  input wire logic rx_parity_err,
  input wire ufc_pkg::ufc_fmt_t fmt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // every taken address phase costs exactly one wait state
  a_one_wait: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("bus wait state not exactly one cycle");
  a_word_len: assert property (fmt.data_bits >= 4'h5 && fmt.data_bits <= 4'h8)
    else $error("word length outside five to eight");
  a_stop_pair: assert property (fmt.stop_halves == 3'h3 |-> fmt.data_bits == 4'h5)
    else $error("one and a half stop bits on a long word");
  a_stop_legal: assert property (fmt.stop_halves inside {3'h2, 3'h3, 3'h4})
    else $error("illegal stop length");
  // break may only pull low; otherwise the line echoes the transmitter
  a_break_low: assert property ($past(hresetn) && tx_line |-> $past(tx_serial))
    else $error("transmit line high without serial data");
  // settled forced mode puts the fixed value on the parity output
  a_forced_par: assert property ((fmt.parity_mode == ufc_pkg::UFC_PAR_FORCED && $stable(fmt)) [*3] |-> tx_parity == fmt.forced_value)
    else $error("forced parity value wrong");
  a_no_parity: assert property ((fmt.parity_mode == ufc_pkg::UFC_PAR_NONE) [*3] |-> !tx_parity && !rx_parity_err)
    else $error("parity activity while parity disabled");
  a_reset_fmt: assert property ($rose(hresetn) |-> fmt == {4'h5, 3'h2, ufc_pkg::UFC_PAR_NONE, 1'b1})
    else $error("format not at reset defaults");
endmodule : ufc_line_format_assertions

bind ufc_line_format ufc_line_format_assertions chk_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
  .tx_serial(tx_serial), .tx_line(tx_line), .tx_parity(tx_parity),
  .rx_parity_err(rx_parity_err), .fmt(fmt));

// >>> tb/ufc_line_peer.sv
// serial side model: characters, received parity bit and a busy transmit stream
module ufc_line_peer (
  input wire logic hclk,
  input wire logic [7:0] char_in,
  input wire logic par_in,
  output logic tx_serial,
  output logic [7:0] tx_char,
  output logic [7:0] rx_char,
  output logic rx_parity_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  // same character both ways so one expected parity serves both checks
  assign tx_char = char_in;
  assign rx_char = char_in;
  assign rx_parity_bit = par_in;
  // stream is redrawn at random every cycle so a stuck transmit output cannot hide
  initial begin
    tx_serial = 1'b0;
    forever begin
      @(posedge hclk);
      tx_serial <= 1'($urandom);
    end
  end
endmodule : ufc_line_peer

// >>> tb/ufc_line_format_test.sv
// self-checking bench for interrupt identification and line format control
module ufc_line_format_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_dp = 1'b0, par = 1'b0;
  logic hreadyout, hresp, tx_serial, tx_line, tx_parity, rx_parity_err, irq, rx_parity_bit;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] ch = 8'h0, tx_char, rx_char, enhanced_feature_register;
  logic [15:0] divisor;
  ufc_pkg::ufc_events_t events = '0;
  ufc_pkg::ufc_fmt_t fmt;
  logic [5:0] codes [7] = '{6'h06, 6'h04, 6'h0c, 6'h02, 6'h00, 6'h10, 6'h20};
  logic [31:0] exp_q [$];
  int miscompares = 0;
  int cmp_count = 0;

  initial forever #2 hclk = ~hclk;

  ufc_line_format dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .events(events),
    .tx_serial(tx_serial), .tx_char(tx_char), .rx_char(rx_char),
    .rx_parity_bit(rx_parity_bit), .tx_line(tx_line), .tx_parity(tx_parity),
    .rx_parity_err(rx_parity_err), .fmt(fmt), .divisor(divisor),
    .enhanced_feature_register(enhanced_feature_register), .irq(irq));

  ufc_line_peer peer_u (.hclk(hclk), .char_in(ch), .par_in(par), .tx_serial(tx_serial),
    .tx_char(tx_char), .rx_char(rx_char), .rx_parity_bit(rx_parity_bit));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one single transfer; waits on hready, no cycle count assumed
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask : rd

  task automatic pulse(input logic [8:0] e);
    events <= ufc_pkg::ufc_events_t'(e);
    @(posedge hclk);
    events <= '0;
    repeat (2) @(posedge hclk);
  endtask : pulse

  // read data is taken at the edge that ends the data phase
  always @(posedge hclk) begin
    if (rd_dp && hreadyout) chk("hrdata", exp_q.pop_front(), hrdata);
    if (rd_dp && hreadyout) chk("hresp", 32'h0, {31'h0, hresp});
    if (hreadyout) rd_dp <= hsel && htrans[1] && !hwrite;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // a hung handshake must not stall the run
  initial begin
    #40000;
    miscompares++;
    results();
  end

  initial begin
    int i;
    int f;
    logic [7:0] v;
    logic [7:0] c;
    logic p;
    void'($urandom(61));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h0c, 32'h0);
    rd(8'h08, 32'h1);
    bus(8'h0c, 1'b1, 32'h80);
    bus(8'h08, 1'b1, 32'h10);
    bus(8'h00, 1'b1, 32'h34);
    bus(8'h04, 1'b1, 32'h12);
    bus(8'h10, 1'b1, 32'h1);
    rd(8'h08, 32'h10);
    rd(8'h04, 32'h12);
    rd(8'h10, 32'h0);
    chk("divisor", 32'h1234, {16'h0, divisor});
    chk("enhanced", 32'h10, {24'h0, enhanced_feature_register});
    bus(8'h0c, 1'b1, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h40, 32'h0);
    bus(8'h04, 1'b1, 32'h7f);
    // each source except xoff alone, fifos off then on
    for (f = 0; f < 2; f++) begin
      bus(8'h10, 1'b1, 32'(f));
      for (i = 0; i < 7; i++) begin
        pulse(9'h100 >> i);
        chk("irq", 32'h1, {31'h0, irq});
        rd(8'h08, {24'h0, {2{f[0]}}, codes[i]});
        rd(8'h08, {24'h0, {2{f[0]}}, 6'h01});
        chk("irq", 32'h0, {31'h0, irq});
      end
    end
    pulse(9'h110);
    rd(8'h08, 32'hc6);
    rd(8'h08, 32'hc0);
    rd(8'h08, 32'hc1);
    pulse(9'h020);
    pulse(9'h100);
    rd(8'h08, 32'hc2);
    rd(8'h08, 32'hc6);
    rd(8'h08, 32'hc1);
    // random formats with one character and a possibly flipped parity bit
    for (i = 0; i < 24; i++) begin
      v = 8'($urandom_range(63));
      c = 8'($urandom) & (8'hff >> (2'h3 - v[1:0]));
      p = v[5] ? ~v[4] : (~^c ^ v[4]);
      f = $urandom_range(1);
      ch <= c;
      par <= p ^ f[0];
      bus(8'h0c, 1'b1, {24'h0, v});
      rd(8'h0c, {24'h0, v});
      chk("word length", 32'h5 + v[1:0], fmt.data_bits);
      chk("stop", v[2] ? (v[1:0] == 2'h0 ? 32'h3 : 32'h4) : 32'h2, fmt.stop_halves);
      chk("parity mode", !v[3] ? 32'h0 : v[5] ? 32'h3 : v[4] ? 32'h2 : 32'h1,
          fmt.parity_mode);
      chk("tx parity", v[3] & p, tx_parity);
      chk("rx parity error", v[3] & f[0], rx_parity_err);
    end
    bus(8'h0c, 1'b1, 32'h43);
    repeat (4) begin
      @(posedge hclk);
      chk("break", 32'h0, tx_line);
    end
    bus(8'h0c, 1'b1, 32'h0);
    // with break cleared the line echoes the serial stream one cycle late
    repeat (4) begin
      p = tx_serial;
      @(posedge hclk);
      chk("tx line", {31'h0, p}, {31'h0, tx_line});
    end
    pulse(9'h002);
    rd(8'h08, 32'hd0);
    rd(8'h08, 32'hd0);
    pulse(9'h001);
    rd(8'h08, 32'hc1);
    bus(8'h0c, 1'b1, 32'h80);
    bus(8'h08, 1'b1, 32'h0);
    bus(8'h0c, 1'b1, 32'h0);
    pulse(9'h00c);
    rd(8'h08, 32'hc1);
    bus(8'h04, 1'b1, 32'h0);
    pulse(9'h080);
    chk("irq", 32'h0, {31'h0, irq});
    results();
  end
endmodule : ufc_line_format_test
